// ==== src/cdf_pkg.sv ====
// cdf_pkg: shared constants of the channel diagnosis flag block.
// assumes an 8-bit serial frame, msb first, one command per frame.
package cdf_pkg;

  // ************************************************************
  // frame format
  // ************************************************************
  localparam int unsigned FRAME_BITS     = 8;
  localparam int unsigned CNT_W          = 4;
  localparam logic [3:0]  FRAME_BITS_CNT = 4'h8;
  // diagnosis overload flags clear on this rising edge (second)
  localparam logic [3:0]  CLEAR_EDGE_IDX = 4'h1;
  // thermal copy is held clear until this rising edge (third)
  localparam logic [3:0]  REARM_EDGE_IDX = 4'h2;

  // ************************************************************
  // command codes in the upper nibble of a write frame
  // ************************************************************
  localparam logic [3:0]  HW_CONFIG_CODE = 4'hc;
  localparam logic [3:0]  DIAG_CTRL_CODE = 4'hd;
  localparam logic [3:0]  LOAD_TYPE_CODE = 4'ha;
  localparam int unsigned CMD_MSB        = 7;
  localparam int unsigned CMD_LSB        = 4;

  // ************************************************************
  // field positions
  // ************************************************************
  localparam int unsigned CLEAR_THERMAL_POS = 0;
  localparam int unsigned CONFIG_LSB        = 1;
  localparam int unsigned CONFIG_MSB        = 2;
  localparam int unsigned SENSE_SEL_LSB     = 0;
  localparam int unsigned SENSE_SEL_MSB     = 2;
  localparam int unsigned LED_LSB           = 0;
  localparam int unsigned LED_MSB           = 2;

  // ************************************************************
  // sense multiplexer codes and reset values
  // ************************************************************
  localparam logic [2:0]  SENSE_OFF_CODE    = 3'h6;
  localparam logic [2:0]  SENSE_SEL_RESET   = 3'h6;
  localparam logic [2:0]  LED_MODE_RESET    = 3'h0;
  localparam logic [1:0]  CONFIG_RESET      = 2'h0;
  localparam int unsigned LED_CHANNELS      = 3;

endpackage

// ==== src/cdf_frame_if.sv ====
// cdf_frame_if: frame events passed from the serial front end to the
// diagnosis core; both ends run on core_clk.
`timescale 1ns/1ps
interface cdf_frame_if;
  logic       frame_start;
  logic       frame_end;
  logic       rise;
  logic [3:0] rise_count;
  logic [7:0] rx_byte;
  logic [7:0] tx_word;

  modport link (
    output frame_start,
    output frame_end,
    output rise,
    output rise_count,
    output rx_byte,
    input  tx_word
  );

  modport core (
    input  frame_start,
    input  frame_end,
    input  rise,
    input  rise_count,
    input  rx_byte,
    output tx_word
  );
endinterface

// ==== src/cdf_spi_frontend.sv ====
// cdf_spi_frontend: samples the serial pins with core_clk, finds the
// clock edges and shifts frames in and out.
// assumes sclk idles low and is several core_clk periods long.
`timescale 1ns/1ps
module cdf_spi_frontend (
  input  wire logic  core_clk,
  input  wire logic  reset,
  input  wire logic  sclk,
  input  wire logic  cs_n,
  input  wire logic  mosi,
  output logic       miso,
  output logic       miso_oe,
  cdf_frame_if.link  fr
);

  // ************************************************************
  // pin synchronisers
  // ************************************************************
  logic       sclk_s1_q, sclk_s2_q, sclk_s3_q;
  logic       cs_n_s1_q, cs_n_s2_q, cs_n_s3_q;
  logic       mosi_s1_q, mosi_s2_q;
  logic [3:0] rise_count_q;
  logic [7:0] rx_q;
  logic [7:0] tx_q;
  logic       active;
  logic       rise;
  logic       fall;

  always_ff @(posedge core_clk) begin
    if (reset) begin
      sclk_s1_q <= 1'b0;
      sclk_s2_q <= 1'b0;
      sclk_s3_q <= 1'b0;
      cs_n_s1_q <= 1'b1;
      cs_n_s2_q <= 1'b1;
      cs_n_s3_q <= 1'b1;
      mosi_s1_q <= 1'b0;
      mosi_s2_q <= 1'b0;
    end else begin
      sclk_s1_q <= sclk;
      sclk_s2_q <= sclk_s1_q;
      sclk_s3_q <= sclk_s2_q;
      cs_n_s1_q <= cs_n;
      cs_n_s2_q <= cs_n_s1_q;
      cs_n_s3_q <= cs_n_s2_q;
      mosi_s1_q <= mosi;
      mosi_s2_q <= mosi_s1_q;
    end
  end

  assign active = ~cs_n_s2_q;
  assign rise   = active & sclk_s2_q & ~sclk_s3_q;
  assign fall   = active & ~sclk_s2_q & sclk_s3_q;

  // ************************************************************
  // edge count and shift registers
  // ************************************************************
  always_ff @(posedge core_clk) begin
    if (reset) begin
      rise_count_q <= 4'h0;
    end else if (fr.frame_start) begin
      rise_count_q <= 4'h0;
    end else if (rise && rise_count_q != 4'hf) begin
      rise_count_q <= rise_count_q + 4'h1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      rx_q <= 8'h00;
    end else if (rise) begin
      rx_q <= {rx_q[6:0], mosi_s2_q};
    end
  end

  // the word is captured at select, so a clear later in the frame
  // cannot change what this frame reports
  always_ff @(posedge core_clk) begin
    if (reset) begin
      tx_q <= 8'h00;
    end else if (fr.frame_start) begin
      tx_q <= fr.tx_word;
    end else if (fall) begin
      tx_q <= {tx_q[6:0], 1'b0};
    end
  end

  assign fr.frame_start = cs_n_s3_q & ~cs_n_s2_q;
  assign fr.frame_end   = ~cs_n_s3_q & cs_n_s2_q;
  assign fr.rise        = rise;
  assign fr.rise_count  = rise_count_q;
  assign fr.rx_byte     = rx_q;
  assign miso           = tx_q[7];
  assign miso_oe        = active;

endmodule

// ==== src/cdf_diag_top.sv ====
// cdf_diag_top: per-channel error flags, thermal latches, sense
// multiplexer and bypass monitor behind the serial frame port.
// assumes channel status inputs are asynchronous digital levels.
//
// How it works
// RL1: the host sends the hardware config command as a write frame with upper nibble 1100, clear-thermal at bit 0, config at bits 1 and 2.
// RL2: a clear-thermal bit of 1 clears every thermal latch, 0 leaves them alone.
// RL3: each error flag is the OR of the thermal copy and the latched overload monitor.
// RL4: overload indications stay latched until reported, then clear on the second rising serial edge.
// RL5: an overtemperature latches the channel off until a clear-thermal command, even when off.
// RL6: after a clear-thermal the thermal copy clears in the next frame and rearms after its third rising edge.
// RL7: a persisting overload sets the error flag again right after it clears.
// RL8: the on-state flag is 1 for limitation, short to ground, dynamic and thermal shutdown, else 0.
// RL9: the bypass monitor reads 1 for a large drain-source voltage and 0 for a small one.
// RL10: the sense output is off for a channel in overcurrent or overtemperature.
// RL11: exactly one channel is routed to the sense pin by the select field, or none.
// RL12: channels 0 to 2 pick their sense ratio from their load-type bit.
// RL13: select code 110 disables the sense output.
// RL14: the bypass monitor compares the channel chosen by the sense select.
// RL15: a dynamic temperature shutdown keeps setting the error flag even after it is read.
// RL16: a load-type bit of 1 means led mode, 0 bulb mode.
// RL17: a set and a clear in the same cycle leave the flag set; the thermal copy in the error flags clears even while its latch is set.
`timescale 1ns/1ps
module cdf_diag_top #(
  parameter int unsigned NUM_CH = 6
) (
  input  wire logic              core_clk,
  input  wire logic              reset,
  input  wire logic              sclk,
  input  wire logic              cs_n,
  input  wire logic              mosi,
  output logic                   miso,
  output logic                   miso_oe,
  input  wire logic [NUM_CH-1:0] overload_mon,
  input  wire logic [NUM_CH-1:0] overtemp_det,
  input  wire logic [NUM_CH-1:0] dyn_temp_shutdown,
  input  wire logic [NUM_CH-1:0] vds_high,
  output logic      [NUM_CH-1:0] thermal_latch,
  output logic      [NUM_CH-1:0] channel_error_flag,
  output logic                   bypass_monitor_status,
  output logic                   sense_enable,
  output logic      [2:0]        sense_select,
  output logic                   sense_led_ratio,
  output logic      [2:0]        led_mode_bit,
  output logic      [1:0]        config_bits
);

  // ************************************************************
  // elaboration checks
  // ************************************************************
  // the 3-bit select must keep code 110 free for the off setting
  if (NUM_CH < cdf_pkg::LED_CHANNELS || NUM_CH > 6) begin : g_bad_ch
    $error("cdf_diag_top: NUM_CH must lie between 3 and 6");
  end

  // ************************************************************
  // serial front end
  // ************************************************************
  cdf_frame_if fr ();

  cdf_spi_frontend u_frontend (
    .core_clk (core_clk),
    .reset    (reset),
    .sclk     (sclk),
    .cs_n     (cs_n),
    .mosi     (mosi),
    .miso     (miso),
    .miso_oe  (miso_oe),
    .fr       (fr)
  );

  // ************************************************************
  // channel input synchronisers
  // ************************************************************
  logic [NUM_CH-1:0] ol_s1_q, ol_s2_q;
  logic [NUM_CH-1:0] ot_s1_q, ot_s2_q;
  logic [NUM_CH-1:0] dt_s1_q, dt_s2_q;
  logic [NUM_CH-1:0] vds_s1_q, vds_s2_q;

  always_ff @(posedge core_clk) begin
    if (reset) begin
      ol_s1_q  <= '0;
      ol_s2_q  <= '0;
      ot_s1_q  <= '0;
      ot_s2_q  <= '0;
      dt_s1_q  <= '0;
      dt_s2_q  <= '0;
      vds_s1_q <= '0;
      vds_s2_q <= '0;
    end else begin
      ol_s1_q  <= overload_mon;
      ol_s2_q  <= ol_s1_q;
      ot_s1_q  <= overtemp_det;
      ot_s2_q  <= ot_s1_q;
      dt_s1_q  <= dyn_temp_shutdown;
      dt_s2_q  <= dt_s1_q;
      vds_s1_q <= vds_high;
      vds_s2_q <= vds_s1_q;
    end
  end

  // ************************************************************
  // command decode
  // ************************************************************
  function automatic logic is_cmd(input logic [7:0] b,
                                  input logic [3:0] code);
    return b[cdf_pkg::CMD_MSB:cdf_pkg::CMD_LSB] == code;
  endfunction

  logic whole_frame;
  logic hw_cfg_wr;
  logic clear_thermal;
  logic diag_ctrl_wr;
  logic load_type_wr;

  assign whole_frame   = fr.frame_end &&
                         fr.rise_count == cdf_pkg::FRAME_BITS_CNT;
  assign hw_cfg_wr     = whole_frame &&
                         is_cmd(fr.rx_byte, cdf_pkg::HW_CONFIG_CODE); // RL1
  assign clear_thermal = hw_cfg_wr &&
                         fr.rx_byte[cdf_pkg::CLEAR_THERMAL_POS]; // RL2
  assign diag_ctrl_wr  = whole_frame &&
                         is_cmd(fr.rx_byte, cdf_pkg::DIAG_CTRL_CODE);
  assign load_type_wr  = whole_frame &&
                         is_cmd(fr.rx_byte, cdf_pkg::LOAD_TYPE_CODE);

  // ************************************************************
  // configuration registers
  // ************************************************************
  logic [2:0] sense_sel_q;
  logic [2:0] led_q;
  logic [1:0] config_q;

  always_ff @(posedge core_clk) begin
    if (reset) begin
      config_q <= cdf_pkg::CONFIG_RESET;
    end else if (hw_cfg_wr) begin
      config_q <= fr.rx_byte[cdf_pkg::CONFIG_MSB:cdf_pkg::CONFIG_LSB];
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      sense_sel_q <= cdf_pkg::SENSE_SEL_RESET;
    end else if (diag_ctrl_wr) begin
      sense_sel_q <=
        fr.rx_byte[cdf_pkg::SENSE_SEL_MSB:cdf_pkg::SENSE_SEL_LSB];
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      led_q <= cdf_pkg::LED_MODE_RESET;
    end else if (load_type_wr) begin
      led_q <= fr.rx_byte[cdf_pkg::LED_MSB:cdf_pkg::LED_LSB]; // RL16
    end
  end

  // ************************************************************
  // thermal latches in the gate control
  // ************************************************************
  logic [NUM_CH-1:0] thermal_q;

  // set wins, so a channel still too hot stays latched off
  always_ff @(posedge core_clk) begin
    if (reset) begin
      thermal_q <= '0;
    end else begin
      thermal_q <= (clear_thermal ? '0 : thermal_q) | ot_s2_q; // RL5 RL17
    end
  end

  // ************************************************************
  // thermal copy in the error flags
  // ************************************************************
  logic              rearm_wait_q;
  logic              rearm_hold_q;
  logic [NUM_CH-1:0] ot_copy_q;
  logic              clear_edge;
  logic              rearm_edge;

  assign clear_edge = fr.rise && fr.rise_count == cdf_pkg::CLEAR_EDGE_IDX;
  assign rearm_edge = fr.rise && fr.rise_count == cdf_pkg::REARM_EDGE_IDX;

  // a clear-thermal command arms a copy clear for the next frame
  always_ff @(posedge core_clk) begin
    if (reset) begin
      rearm_wait_q <= 1'b0;
    end else if (clear_thermal) begin
      rearm_wait_q <= 1'b1; // RL6
    end else if (clear_edge) begin
      rearm_wait_q <= 1'b0;
    end
  end

  // copy is held clear from the second to the third rising edge
  always_ff @(posedge core_clk) begin
    if (reset) begin
      rearm_hold_q <= 1'b0;
    end else if (clear_edge && rearm_wait_q) begin
      rearm_hold_q <= 1'b1; // RL6
    end else if (rearm_edge || fr.frame_end) begin
      rearm_hold_q <= 1'b0;
    end
  end

  // the frame after the command still reports the old thermal state,
  // because its word was captured before the copy clears
  always_ff @(posedge core_clk) begin
    if (reset) begin
      ot_copy_q <= '0;
    end else if ((clear_edge && rearm_wait_q) || rearm_hold_q) begin
      ot_copy_q <= '0; // RL6
    end else begin
      ot_copy_q <= ot_copy_q | thermal_q;
    end
  end

  // ************************************************************
  // overload flags
  // ************************************************************
  logic [NUM_CH-1:0] ol_flag_q;
  logic [NUM_CH-1:0] ol_set;

  // dynamic shutdown counts as overload: it is set again when read
  assign ol_set = ol_s2_q | dt_s2_q; // RL8 RL15

  always_ff @(posedge core_clk) begin
    if (reset) begin
      ol_flag_q <= '0;
    end else begin
      ol_flag_q <= (clear_edge ? '0 : ol_flag_q) | ol_set; // RL4 RL7 RL17
    end
  end

  // ************************************************************
  // diagnosis word
  // ************************************************************
  logic [NUM_CH-1:0] err;
  logic [7:0]        diag_word;

  assign err       = ol_flag_q | ot_copy_q; // RL3
  assign diag_word = {1'b0, bypass_monitor_status,
                      {(6 - NUM_CH){1'b0}}, err};
  assign fr.tx_word = diag_word;

  // ************************************************************
  // sense multiplexer and bypass monitor
  // ************************************************************
  logic       sel_valid;
  logic       sel_fault;
  logic       sel_vds;
  logic       sel_led;
  logic       sense_en_q;
  logic       bypass_q;
  logic       led_ratio_q;

  always_comb begin
    sel_valid = sense_sel_q != cdf_pkg::SENSE_OFF_CODE &&
                32'(sense_sel_q) < NUM_CH; // RL13
    sel_fault = 1'b0;
    sel_vds   = 1'b0;
    sel_led   = 1'b0;
    for (int i = 0; i < NUM_CH; i++) begin
      if (sel_valid && 32'(sense_sel_q) == i) begin
        sel_fault = ol_s2_q[i] | dt_s2_q[i] | thermal_q[i]; // RL10
        sel_vds   = vds_s2_q[i]; // RL14
        if (i < cdf_pkg::LED_CHANNELS) begin
          sel_led = led_q[i]; // RL12
        end
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      sense_en_q  <= 1'b0;
      bypass_q    <= 1'b0;
      led_ratio_q <= 1'b0;
    end else begin
      sense_en_q  <= sel_valid & ~sel_fault; // RL10 RL11
      bypass_q    <= sel_vds; // RL9 RL14
      led_ratio_q <= sel_led; // RL12
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  assign thermal_latch         = thermal_q;
  assign channel_error_flag    = err;
  assign bypass_monitor_status = bypass_q;
  assign sense_enable          = sense_en_q;
  assign sense_select          = sense_sel_q;
  assign sense_led_ratio       = led_ratio_q;
  assign led_mode_bit          = led_q;
  assign config_bits           = config_q;

endmodule

// ==== test/cdf_diag_assertions.sv ====
// cdf_diag_assertions: port-level checks of the diagnosis flag block.
// assumes one core_clk domain and the synchronous active-high reset.
`timescale 1ns/1ps
module cdf_diag_assertions #(
  parameter int unsigned NUM_CH = 6
) (
  input logic              core_clk,
  input logic              reset,
  input logic              cs_n,
  input logic              miso_oe,
  input logic [NUM_CH-1:0] overload_mon,
  input logic [NUM_CH-1:0] overtemp_det,
  input logic [NUM_CH-1:0] dyn_temp_shutdown,
  input logic [NUM_CH-1:0] vds_high,
  input logic [NUM_CH-1:0] thermal_latch,
  input logic [NUM_CH-1:0] channel_error_flag,
  input logic              bypass_monitor_status,
  input logic              sense_enable,
  input logic [2:0]        sense_select,
  input logic              sense_led_ratio,
  input logic [2:0]        led_mode_bit
);
  // ************************************************************
  // properties
  // ************************************************************
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (reset);

  property p_sense_off;
    (sense_select == 3'h6)[*2] |-> !sense_enable && !bypass_monitor_status;
  endproperty
  a_sense_off: assert property (p_sense_off)
    else $error("sense active while select is off");

  property p_sense_fault;
    (sense_select == 3'h1 && thermal_latch[1])[*3] |-> !sense_enable;
  endproperty
  a_sense_fault: assert property (p_sense_fault)
    else $error("sense active on a latched channel");

  // async inputs pass two sync stages, hence the few cycles of slack
  property p_latch_set;
    overtemp_det[1] |-> ##[1:4] thermal_latch[1];
  endproperty
  a_latch_set: assert property (p_latch_set)
    else $error("overtemperature not latched");

  property p_latch_hold;
    $fell(thermal_latch[1]) |-> cs_n && !overtemp_det[1];
  endproperty
  a_latch_hold: assert property (p_latch_hold)
    else $error("thermal latch dropped without a command");

  property p_dyn_flag;
    dyn_temp_shutdown[0][*6] |-> channel_error_flag[0];
  endproperty
  a_dyn_flag: assert property (p_dyn_flag)
    else $error("dynamic shutdown not flagged");

  property p_ovl_flag;
    overload_mon[2][*6] |-> channel_error_flag[2];
  endproperty
  a_ovl_flag: assert property (p_ovl_flag)
    else $error("persistent overload not flagged");

  property p_flag_drop;
    $fell(channel_error_flag[2]) |-> !cs_n;
  endproperty
  a_flag_drop: assert property (p_flag_drop)
    else $error("error flag cleared outside a frame");

  property p_bypass;
    (sense_select == 3'h3 && vds_high[3])[*5] |-> bypass_monitor_status;
  endproperty
  a_bypass: assert property (p_bypass)
    else $error("bypass monitor ignores selected channel");

  property p_led_ratio;
    (sense_select == 3'h0 && led_mode_bit[0])[*3] |-> sense_led_ratio;
  endproperty
  a_led_ratio: assert property (p_led_ratio)
    else $error("led ratio not applied");

  // the word can only reach the host while the pin is driven
  property p_miso_oe;
    (!cs_n)[*3] |-> miso_oe;
  endproperty
  a_miso_oe: assert property (p_miso_oe)
    else $error("serial output not driven inside a frame");
endmodule

bind cdf_diag_top cdf_diag_assertions #(.NUM_CH(NUM_CH)) u_chk (
  .core_clk(core_clk), .reset(reset), .cs_n(cs_n), .miso_oe(miso_oe),
  .overload_mon(overload_mon), .overtemp_det(overtemp_det),
  .dyn_temp_shutdown(dyn_temp_shutdown), .vds_high(vds_high),
  .thermal_latch(thermal_latch), .channel_error_flag(channel_error_flag),
  .bypass_monitor_status(bypass_monitor_status),
  .sense_enable(sense_enable), .sense_select(sense_select),
  .sense_led_ratio(sense_led_ratio), .led_mode_bit(led_mode_bit)
);

// ==== test/cdf_spi_host.sv ====
// cdf_spi_host: behavioural serial host, one byte per frame, mode 0.
// assumes the device samples the pins with its own faster clock.
`timescale 1ns/1ps
module cdf_spi_host (
  output logic      sclk,
  output logic      cs_n,
  output logic      mosi,
  input  wire logic miso
);
  // ************************************************************
  // frame driver
  // ************************************************************
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b1;
  end

  // 48 ns link period; sclk rests low between frames
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    cs_n = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      mosi = tx[i];
      #24;
      sclk = 1'b1;
      rx[i] = miso;
      #24;
      sclk = 1'b0;
    end
    #24;
    cs_n = 1'b1;
    // released line shows no stale bit
    mosi = ~mosi;
    #100;
  endtask
endmodule

// ==== test/cdf_diag_top_bench.sv ====
// cdf_diag_top_bench: self-checking bench of the diagnosis flag block.
// assumes the host model and the bound checker are compiled alongside.
`timescale 1ns/1ps
module cdf_diag_top_bench;
  localparam int unsigned NCH = 6;
  logic           core_clk;
  logic           reset;
  logic           sclk;
  logic           cs_n;
  logic           mosi;
  logic           miso;
  logic           miso_oe;
  logic [NCH-1:0] ovl;
  logic [NCH-1:0] otemp;
  logic [NCH-1:0] dyn;
  logic [NCH-1:0] vds;
  logic [NCH-1:0] tlatch;
  logic [NCH-1:0] err;
  logic           bypass;
  logic           sen_en;
  logic           led_ratio;
  logic [2:0]     sel;
  logic [2:0]     led;
  logic [1:0]     cfg;
  logic [7:0]     rx;
  int             num_errors;
  int             n_tests;

  // ************************************************************
  // instances and clock
  // ************************************************************
  cdf_diag_top #(.NUM_CH(NCH)) DUT (
    .core_clk(core_clk), .reset(reset), .sclk(sclk), .cs_n(cs_n),
    .mosi(mosi), .miso(miso), .miso_oe(miso_oe), .overload_mon(ovl),
    .overtemp_det(otemp), .dyn_temp_shutdown(dyn), .vds_high(vds),
    .thermal_latch(tlatch), .channel_error_flag(err),
    .bypass_monitor_status(bypass), .sense_enable(sen_en),
    .sense_select(sel), .sense_led_ratio(led_ratio),
    .led_mode_bit(led), .config_bits(cfg)
  );
  cdf_spi_host u_host (.sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso));

  always #2.5 core_clk = ~core_clk;

  // ************************************************************
  // helpers
  // ************************************************************
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // step off the edge so outputs are read once they have settled
  task automatic idle(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  // odd offset keeps the link out of phase with core_clk
  task automatic frame(input logic [7:0] b);
    @(posedge core_clk);
    #1.3;
    u_host.xfer(b, rx);
  endtask

  task automatic tally_and_finish;
    $display("errors=%0d tests=%0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic s_reset;
    check({sel, led, cfg}, 8'hc0);
    check({2'h0, err | tlatch}, 8'h00);
    check({5'h0, sen_en, bypass, miso_oe}, 8'h00);
  endtask

  task automatic s_overload;
    @(posedge core_clk) ovl <= 6'h04;
    idle(10);
    @(posedge core_clk) ovl <= 6'h00;
    idle(10);
    check({2'h0, err}, 8'h04);
    frame(8'h00);
    check(rx, 8'h04);
    check({2'h0, err}, 8'h00);
    @(posedge core_clk) ovl <= 6'h04;
    idle(10);
    frame(8'h00);
    check({2'h0, err}, 8'h04);
    @(posedge core_clk) ovl <= 6'h00;
    dyn <= 6'h01;
    idle(10);
    frame(8'h00);
    check(rx, 8'h05);
    check({2'h0, err}, 8'h01);
    @(posedge core_clk) dyn <= 6'h00;
    idle(10);
    frame(8'h00);
    check(rx, 8'h01);
    check({2'h0, err}, 8'h00);
  endtask

  task automatic s_thermal;
    @(posedge core_clk) otemp <= 6'h02;
    idle(10);
    @(posedge core_clk) otemp <= 6'h00;
    idle(10);
    check({2'h0, tlatch}, 8'h02);
    frame(8'hd1);
    idle(3);
    check({7'h0, sen_en}, 8'h00);
    frame(8'hc0);
    check({2'h0, tlatch}, 8'h02);
    check({2'h0, err}, 8'h02);
    frame(8'hc1);
    check({2'h0, tlatch}, 8'h00);
    frame(8'h00);
    check(rx, 8'h02);
    check({2'h0, err}, 8'h00);
  endtask

  task automatic s_mux;
    frame(8'ha5);
    check({5'h0, led}, 8'h05);
    // a latched channel makes a config write without clear observable
    @(posedge core_clk) otemp <= 6'h20;
    idle(10);
    @(posedge core_clk) otemp <= 6'h00;
    frame(8'hc6);
    check({6'h0, cfg}, 8'h03);
    check({2'h0, tlatch}, 8'h20);
    frame(8'hc7);
    check({2'h0, tlatch}, 8'h00);
    for (int i = 0; i < 8; i++) begin
      @(posedge core_clk) vds <= 6'h01 << i;
      frame(8'hd0 | 8'(i));
      idle(6);
      check({5'h0, sel}, 8'(i));
      check({6'h0, sen_en, bypass}, (i < 6) ? 8'h03 : 8'h00);
      check({7'h0, led_ratio}, (i == 0 || i == 2) ? 8'h01 : 8'h00);
    end
  endtask

  // ************************************************************
  // main sequence and watchdog
  // ************************************************************
  initial begin
    core_clk = 1'b0;
    reset = 1'b1;
    ovl = '0;
    otemp = '0;
    dyn = '0;
    vds = '0;
    num_errors = 0;
    n_tests = 0;
    idle(10);
    reset <= 1'b0;
    idle(3);
    s_reset();
    s_overload();
    s_thermal();
    s_mux();
    tally_and_finish();
  end

  initial begin
    #100000;
    num_errors++;
    tally_and_finish();
  end
endmodule
